// File: core/spi_byte_fifo.sv
`timescale 1ns/100ps
`default_nettype none

module spi_byte_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input  wire logic             clk,
  input  wire logic             resetn,
  input  wire logic [WIDTH-1:0] in_data,
  input  wire logic             in_valid,
  output logic                  in_ready,
  output logic [WIDTH-1:0]      out_data,
  output logic                  out_valid,
  input  wire logic             out_ready
);

  localparam int CW = $clog2(DEPTH + 1);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [CW-1:0]               count;
    logic                        not_empty;
    logic                        not_full;
  } fifo_state_s;

  localparam fifo_state_s RST = '{mem: '0, count: '0, not_empty: 1'b0, not_full: 1'b1};

  fifo_state_s st_ff;
  fifo_state_s nxt_st;
  logic        push;
  logic        pop;
  logic [CW-1:0] wr_idx;

  ////////////////////////////////////////////////////////////////////////
  // shift-register queue, head always in a flop
  always_comb begin
    nxt_st = st_ff;
    push   = in_valid & st_ff.not_full;
    pop    = out_ready & st_ff.not_empty;
    wr_idx = pop ? CW'(st_ff.count - CW'(1)) : st_ff.count;
    if (pop) begin
      for (int i = 0; i < DEPTH - 1; i++) begin
        nxt_st.mem[i] = st_ff.mem[i+1];
      end
      nxt_st.mem[DEPTH-1] = '0;
    end
    if (push) begin
      nxt_st.mem[wr_idx] = in_data;
    end
    nxt_st.count     = CW'(st_ff.count + CW'(push) - CW'(pop));
    nxt_st.not_empty = (nxt_st.count != '0);
    nxt_st.not_full  = (nxt_st.count != CW'(DEPTH));
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      st_ff <= RST;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign in_ready  = st_ff.not_full;
  assign out_data  = st_ff.mem[0];
  assign out_valid = st_ff.not_empty;

endmodule : spi_byte_fifo

`default_nettype wire

// File: core/spi_master_port.sv
`timescale 1ns/100ps
`default_nettype none
`include "spi_master_port_defines.svh"

module spi_master_port
  import spi_master_port_pkg::*;
#(
  parameter int GPIO_W     = `SMP_GPIO_SEL_W,
  parameter int FIFO_DEPTH = `SMP_FIFO_DEPTH
) (
  input  wire logic                   clk,
  input  wire logic                   resetn,
  input  wire logic                   enable,
  input  wire spi_cfg_s               link_cfg,
  input  wire logic                   slave_select_assert,
  input  wire logic [GPIO_W-1:0]      gpio_select_in,
  input  wire logic                   req_valid,
  input  wire xfer_req_s              req,
  output logic                        req_ready,
  output logic                        busy,
  output logic                        done,
  input  wire logic [`SMP_BYTE_W-1:0] tx_data,
  input  wire logic                   tx_valid,
  output logic                        tx_ready,
  output logic [`SMP_BYTE_W-1:0]      rx_data,
  output logic                        rx_valid,
  input  wire logic                   rx_ready,
  output logic                        sclk_out,
  output logic                        mosi_out,
  input  wire logic                   miso_in,
  output logic                        miso_input_enable,
  output logic                        slave_select_out,
  output logic [GPIO_W-1:0]           gpio_select_out
);

  typedef struct packed {
    engine_s             eng;
    logic [GPIO_W-1:0]   gpio;
  } port_state_s;

  localparam port_state_s RST = '0;

  port_state_s               st_ff;
  port_state_s               nxt_st;
  logic [`SMP_BYTE_W-1:0]    txq_data;
  logic                      txq_valid;
  logic                      txq_pop;
  logic                      rxq_ready;
  logic                      rxq_push;
  logic [`SMP_BYTE_W-1:0]    load_byte;
  logic                      lead_edge;
  logic                      sample_edge;

  ////////////////////////////////////////////////////////////////////////
  // helpers

  function automatic logic [`SMP_HALF_W-1:0] clamp_half(input logic [`SMP_HALF_W-1:0] h);
    if (h < `SMP_HALF_W'(`SMP_HALF_MIN)) begin
      return `SMP_HALF_W'(`SMP_HALF_MIN);
    end else if (h > `SMP_HALF_W'(`SMP_HALF_MAX)) begin
      return `SMP_HALF_W'(`SMP_HALF_MAX);
    end else begin
      return h;
    end
  endfunction : clamp_half

  function automatic logic [`SMP_LEN_W-1:0] clamp_len(input logic [`SMP_LEN_W-1:0] l);
    if (l > `SMP_LEN_W'(`SMP_MAX_BYTES)) begin
      return `SMP_LEN_W'(`SMP_MAX_BYTES);
    end else begin
      return l;
    end
  endfunction : clamp_len

  function automatic logic [`SMP_HALF_W-1:0] reload(input logic [`SMP_HALF_W-1:0] h);
    return `SMP_HALF_W'(h - `SMP_HALF_W'(1));
  endfunction : reload

  ////////////////////////////////////////////////////////////////////////
  // byte queues toward and from firmware

  spi_byte_fifo #(
    .WIDTH (`SMP_BYTE_W),
    .DEPTH (FIFO_DEPTH)
  ) u_tx_fifo (
    .clk       (clk),
    .resetn    (resetn),
    .in_data   (tx_data),
    .in_valid  (tx_valid),
    .in_ready  (tx_ready),
    .out_data  (txq_data),
    .out_valid (txq_valid),
    .out_ready (txq_pop)
  );

  spi_byte_fifo #(
    .WIDTH (`SMP_BYTE_W),
    .DEPTH (FIFO_DEPTH)
  ) u_rx_fifo (
    .clk       (clk),
    .resetn    (resetn),
    .in_data   (st_ff.eng.rx_sh),
    .in_valid  (rxq_push),
    .in_ready  (rxq_ready),
    .out_data  (rx_data),
    .out_valid (rx_valid),
    .out_ready (rx_ready)
  );

  ////////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    nxt_st      = st_ff;
    txq_pop     = 1'b0;
    rxq_push    = 1'b0;
    load_byte   = `SMP_FILL_BYTE;
    lead_edge   = 1'b0;
    sample_edge = 1'b0;

    nxt_st.eng.done = 1'b0;

    // data in pin: two-flop synchroniser
    nxt_st.eng.miso_s1 = miso_in;
    nxt_st.eng.miso_s2 = st_ff.eng.miso_s1;

    nxt_st.eng.miso_ie = enable;

    nxt_st.eng.ss = link_cfg.select_active_high ? slave_select_assert : ~slave_select_assert;

    nxt_st.gpio = gpio_select_in;

    unique case (st_ff.eng.state)
      ST_IDLE: begin
        nxt_st.eng.sclk      = link_cfg.clock_polarity_select;
        nxt_st.eng.mosi      = `SMP_IDLE_MOSI;
        nxt_st.eng.busy      = 1'b0;
        nxt_st.eng.req_ready = enable;
        if (enable && st_ff.eng.req_ready && req_valid) begin
          nxt_st.eng.req_ready  = 1'b0;
          nxt_st.eng.busy       = 1'b1;
          nxt_st.eng.write      = req.write;
          nxt_st.eng.cpol       = link_cfg.clock_polarity_select;
          nxt_st.eng.cpha       = link_cfg.clock_phase_select;
          // half period never below SMP_HALF_MIN (16 clocks)
          nxt_st.eng.half_len   = clamp_half(link_cfg.half_period);
          nxt_st.eng.bytes_left = clamp_len(req.len);
          nxt_st.eng.state      = (req.len == '0) ? ST_DONE : ST_LOAD;
        end
      end

      ST_LOAD: begin
        load_byte = st_ff.eng.write ? txq_data : `SMP_FILL_BYTE;
        if (!st_ff.eng.write || txq_valid) begin
          txq_pop             = st_ff.eng.write;
          nxt_st.eng.edge_cnt = '0;
          nxt_st.eng.half_cnt = reload(st_ff.eng.half_len);
          nxt_st.eng.rx_sh    = '0;
          // phase zero presents bit before first edge
          if (!st_ff.eng.cpha) begin
            nxt_st.eng.mosi  = load_byte[`SMP_MSB];
            nxt_st.eng.tx_sh = {load_byte[`SMP_MSB-1:0], 1'b0};
          end else begin
            nxt_st.eng.tx_sh = load_byte;
          end
          nxt_st.eng.state = ST_SHIFT;
        end
      end

      ST_SHIFT: begin
        if (st_ff.eng.half_cnt != '0) begin
          nxt_st.eng.half_cnt = `SMP_HALF_W'(st_ff.eng.half_cnt - `SMP_HALF_W'(1));
        end else begin
          nxt_st.eng.half_cnt = reload(st_ff.eng.half_len);
          nxt_st.eng.sclk     = ~st_ff.eng.sclk;
          nxt_st.eng.edge_cnt = `SMP_EDGE_W'(st_ff.eng.edge_cnt + `SMP_EDGE_W'(1));
          lead_edge           = ~st_ff.eng.edge_cnt[0];
          sample_edge         = lead_edge ^ st_ff.eng.cpha;
          if (sample_edge) begin
            nxt_st.eng.rx_sh = {st_ff.eng.rx_sh[`SMP_MSB-1:0], st_ff.eng.miso_s2};
          end else if (st_ff.eng.edge_cnt != `SMP_LAST_EDGE) begin
            nxt_st.eng.mosi  = st_ff.eng.tx_sh[`SMP_MSB];
            nxt_st.eng.tx_sh = {st_ff.eng.tx_sh[`SMP_MSB-1:0], 1'b0};
          end
          if (st_ff.eng.edge_cnt == `SMP_LAST_EDGE) begin
            nxt_st.eng.state = ST_STORE;
          end
        end
      end

      ST_STORE: begin
        if (st_ff.eng.write || rxq_ready) begin
          rxq_push              = ~st_ff.eng.write;
          nxt_st.eng.bytes_left = `SMP_LEN_W'(st_ff.eng.bytes_left - `SMP_LEN_W'(1));
          nxt_st.eng.state      = (st_ff.eng.bytes_left == `SMP_LEN_W'(1)) ? ST_DONE : ST_LOAD;
        end
      end

      ST_DONE: begin
        nxt_st.eng.done      = 1'b1;
        nxt_st.eng.busy      = 1'b0;
        nxt_st.eng.req_ready = enable;
        nxt_st.eng.mosi      = `SMP_IDLE_MOSI;
        nxt_st.eng.sclk      = st_ff.eng.cpol;
        nxt_st.eng.state     = ST_IDLE;
      end
    endcase

    // disable aborts any transfer
    if (!enable) begin
      nxt_st.eng.state     = ST_IDLE;
      nxt_st.eng.sclk      = link_cfg.clock_polarity_select;
      nxt_st.eng.mosi      = `SMP_IDLE_MOSI;
      nxt_st.eng.busy      = 1'b0;
      nxt_st.eng.done      = 1'b0;
      nxt_st.eng.req_ready = 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // state register

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      st_ff <= RST;
    end else begin
      st_ff <= nxt_st;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // pins and status, straight from flops

  assign sclk_out          = st_ff.eng.sclk;
  assign mosi_out          = st_ff.eng.mosi;
  assign slave_select_out  = st_ff.eng.ss;
  assign gpio_select_out   = st_ff.gpio;
  assign miso_input_enable = st_ff.eng.miso_ie;
  assign req_ready         = st_ff.eng.req_ready;
  assign busy              = st_ff.eng.busy;
  assign done              = st_ff.eng.done;

endmodule : spi_master_port

`default_nettype wire

// File: dv/spi_master_port_checker.sv
`timescale 1ns/100ps
`default_nettype none

module spi_master_port_checker
  import spi_master_port_pkg::*;
#(
  parameter int GPIO_W = 4
) (
  input wire logic              clk,
  input wire logic              resetn,
  input wire logic              enable,
  input wire spi_cfg_s          link_cfg,
  input wire logic              slave_select_assert,
  input wire logic [GPIO_W-1:0] gpio_select_in,
  input wire logic              req_valid,
  input wire xfer_req_s         req,
  input wire logic              req_ready,
  input wire logic              busy,
  input wire logic              done,
  input wire logic              sclk_out,
  input wire logic              miso_input_enable,
  input wire logic              slave_select_out,
  input wire logic [GPIO_W-1:0] gpio_select_out
);
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  ////////////////////////////////////////
  chk_sel_level: assert property (resetn |=> slave_select_out ==
    ($past(link_cfg.select_active_high) ~^ $past(slave_select_assert))) else $error("select level wrong");
  chk_gpio_copy: assert property (resetn |=> gpio_select_out == $past(gpio_select_in))
    else $error("extra select not copied");
  chk_input_off: assert property (resetn |=> miso_input_enable == $past(enable))
    else $error("data in buffer state wrong");
  chk_idle_clock: assert property (req_ready && $past(req_ready) &&
    $stable(link_cfg.clock_polarity_select) |-> sclk_out == link_cfg.clock_polarity_select)
    else $error("serial clock not at rest level");
  chk_clock_half: assert property (busy && $changed(sclk_out) |=> $stable(sclk_out) [*8])
    else $error("serial clock phase too short");
  chk_accept_busy: assert property (req_valid && req_ready && enable |=> busy)
    else $error("accepted request not busy");
  chk_zero_len: assert property (req_valid && req_ready && enable && req.len == 8'h00 |-> ##2 done)
    else $error("empty request not completed");
  chk_done_pulse: assert property (done |-> !busy ##1 !done)
    else $error("completion pulse wrong");
  chk_busy_excl: assert property (busy |-> !req_ready)
    else $error("ready while busy");
  chk_refuse_off: assert property (!enable |=> !req_ready && !busy)
    else $error("disabled port active");
endmodule : spi_master_port_checker

`default_nettype wire

// File: dv/spi_slave_model.sv
`timescale 1ns/100ps
`default_nettype none

module spi_slave_model (
  input  wire logic       sclk,
  input  wire logic       mosi,
  input  wire logic       cpol,
  input  wire logic       cpha,
  input  wire logic       sync,
  input  wire logic [7:0] reply,
  output logic            miso,
  output logic [7:0]      got
);
  logic [2:0] out_idx;

  initial begin
    out_idx = 3'h0;
    got = 8'h00;
  end
  ////////////////////////////////////////
  // select ignored entirely
  always @(posedge sync) begin
    out_idx = cpha ? 3'h7 : 3'h0;
  end
  always @(sclk) begin
    if (((sclk !== cpol) ^ cpha) == 1'b1) begin
      got = {got[6:0], mosi};
    end else begin
      out_idx = out_idx + 3'h1;
    end
  end
  assign miso = reply[3'h7 - out_idx];
endmodule : spi_slave_model

`default_nettype wire

// File: dv/test_spi_master_port.sv
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin failures++; $display("BAD %0t %h %h", $time, a, b); end end
`define WAITFOR(c) begin int k; k = 0; @(posedge clk); \
  while ((c) !== 1'b1 && k < 9000) begin k++; @(posedge clk); end \
  if (k >= 9000) begin failures++; stop_test(); end end

module test_spi_master_port
  import spi_master_port_pkg::*;
;
  logic       clk, resetn, enable, slave_select_assert, req_valid, tx_valid, rx_ready, sync;
  logic       req_ready, busy, done, tx_ready, rx_valid, sclk_out, mosi_out, miso_in;
  logic       miso_input_enable, slave_select_out;
  spi_cfg_s   link_cfg;
  xfer_req_s  req;
  logic [3:0] gpio_select_in, gpio_select_out;
  logic [7:0] tx_data, rx_data, reply, got;
  int         failures, samples_checked;

  spi_master_port #(.GPIO_W(4), .FIFO_DEPTH(8)) spi_master_port_inst (
    .clk(clk), .resetn(resetn), .enable(enable), .link_cfg(link_cfg), .slave_select_assert(slave_select_assert),
    .gpio_select_in(gpio_select_in), .req_valid(req_valid), .req(req), .req_ready(req_ready), .busy(busy),
    .done(done), .tx_data(tx_data), .tx_valid(tx_valid), .tx_ready(tx_ready), .rx_data(rx_data),
    .rx_valid(rx_valid), .rx_ready(rx_ready), .sclk_out(sclk_out), .mosi_out(mosi_out), .miso_in(miso_in),
    .miso_input_enable(miso_input_enable), .slave_select_out(slave_select_out), .gpio_select_out(gpio_select_out));

  spi_slave_model spi_slave_model_inst (.sclk(sclk_out), .mosi(mosi_out), .cpol(link_cfg.clock_polarity_select),
    .cpha(link_cfg.clock_phase_select), .sync(sync), .reply(reply), .miso(miso_in), .got(got));

  initial clk = 1'b0;
  always #4 clk = ~clk;
  ////////////////////////////////////////
  task automatic stop_test();
    if (failures == 0 && samples_checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : stop_test

  task automatic push(input int n, input logic [7:0] b0);
    tx_valid <= 1'b1;
    for (int i = 0; i < n; i++) begin
      tx_data <= b0 + 8'(i);
      `WAITFOR(tx_ready)
    end
    tx_valid <= 1'b0;
  endtask : push

  task automatic drain(input int n, input logic [7:0] exp);
    rx_ready <= 1'b1;
    for (int i = 0; i < n; i++) begin
      `WAITFOR(rx_valid)
      `CHK(rx_data, exp)
    end
    rx_ready <= 1'b0;
    @(posedge clk);
    `CHK(rx_valid, 1'b0)
  endtask : drain

  task automatic xfer(input logic wr, input logic [7:0] len, input logic [1:0] mode, input logic [7:0] rep,
                      input logic [15:0] half);
    link_cfg <= '{mode[1], mode[0], 1'b0, half};
    reply <= rep;
    repeat (2) @(posedge clk);
    sync <= 1'b1;
    @(posedge clk);
    sync <= 1'b0;
    req <= '{wr, len};
    req_valid <= 1'b1;
    `WAITFOR(req_ready)
    req_valid <= 1'b0;
    `WAITFOR(done)
  endtask : xfer
  ////////////////////////////////////////
  task automatic sel_scen();
    gpio_select_in <= 4'ha;
    slave_select_assert <= 1'b1;
    link_cfg.select_active_high <= 1'b1;
    repeat (2) @(posedge clk);
    `CHK(slave_select_out, 1'b1)
    `CHK(gpio_select_out, 4'ha)
    link_cfg.select_active_high <= 1'b0;
    gpio_select_in <= 4'h5;
    repeat (2) @(posedge clk);
    `CHK(slave_select_out, 1'b0)
  endtask : sel_scen

  task automatic dis_scen();
    enable <= 1'b0;
    req <= '{1'b0, 8'h01};
    req_valid <= 1'b1;
    repeat (3) @(posedge clk);
    `CHK(miso_input_enable, 1'b0)
    `CHK(busy, 1'b0)
    req_valid <= 1'b0;
    enable <= 1'b1;
    repeat (2) @(posedge clk);
    `CHK(miso_input_enable, 1'b1)
  endtask : dis_scen

  task automatic mode_scen();
    for (int m = 0; m < 4; m++) begin
      xfer(1'b0, 8'h01, m[1:0], 8'h35 + 8'(m), 16'h0010);
      `CHK(got, 8'hff)
      `CHK(sclk_out, m[1])
      drain(1, 8'h35 + 8'(m));
      push(1, 8'hc6 - 8'(m));
      xfer(1'b1, 8'h01, m[1:0], 8'h00, 16'h0010);
      `CHK(got, 8'hc6 - 8'(m))
    end
  endtask : mode_scen

  task automatic fifo_scen();
    push(8, 8'h10);
    @(posedge clk);
    `CHK(tx_ready, 1'b0)
    xfer(1'b1, 8'h08, 2'b00, 8'h5a, 16'h0003);
    `CHK(got, 8'h17)
    xfer(1'b0, 8'h08, 2'b11, 8'ha3, 16'h0010);
    drain(8, 8'ha3);
    xfer(1'b0, 8'h00, 2'b00, 8'h00, 16'h0010);
  endtask : fifo_scen

  initial begin
    failures = 0;
    samples_checked = 0;
    resetn = 1'b0;
    enable = 1'b1;
    link_cfg = '{1'b0, 1'b0, 1'b0, 16'h0010};
    req = '0;
    {slave_select_assert, req_valid, tx_valid, rx_ready, sync} = 5'h00;
    {gpio_select_in, tx_data, reply} = 20'h00000;
    repeat (20) @(posedge clk);
    resetn <= 1'b1;
    repeat (2) @(posedge clk);
    sel_scen();
    dis_scen();
    mode_scen();
    fifo_scen();
    stop_test();
  end
endmodule : test_spi_master_port

bind spi_master_port spi_master_port_checker #(.GPIO_W(GPIO_W)) spi_master_port_checker_inst (
  .clk(clk), .resetn(resetn), .enable(enable), .link_cfg(link_cfg), .slave_select_assert(slave_select_assert),
  .gpio_select_in(gpio_select_in), .req_valid(req_valid), .req(req), .req_ready(req_ready), .busy(busy),
  .done(done), .sclk_out(sclk_out), .miso_input_enable(miso_input_enable), .slave_select_out(slave_select_out),
  .gpio_select_out(gpio_select_out));

`default_nettype wire

// File: shared/spi_master_port_defines.svh
`ifndef SPI_MASTER_PORT_DEFINES_SVH
`define SPI_MASTER_PORT_DEFINES_SVH

// system clock and serial clock limits
`define SMP_SYS_CLK_HZ     125000000
`define SMP_SCLK_MAX_HZ    4000000
`define SMP_SCLK_MIN_HZ    100000
// half period bounds in system clocks
`define SMP_HALF_MIN       ((`SMP_SYS_CLK_HZ + 2 * `SMP_SCLK_MAX_HZ - 1) / (2 * `SMP_SCLK_MAX_HZ))
`define SMP_HALF_MAX       (`SMP_SYS_CLK_HZ / (2 * `SMP_SCLK_MIN_HZ))
`define SMP_HALF_W         16
// transfer shape
`define SMP_MAX_BYTES      128
`define SMP_LEN_W          8
`define SMP_BYTE_W         8
`define SMP_MSB            7
`define SMP_EDGE_W         4
`define SMP_LAST_EDGE      4'hf
`define SMP_FILL_BYTE      8'hff
`define SMP_IDLE_MOSI      1'b0
// buffering and extra selects
`define SMP_FIFO_DEPTH     8
`define SMP_GPIO_SEL_W     4

`endif

// File: shared/spi_master_port_pkg.sv
`include "spi_master_port_defines.svh"

package spi_master_port_pkg;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_LOAD  = 3'b001,
    ST_SHIFT = 3'b010,
    ST_STORE = 3'b011,
    ST_DONE  = 3'b100
  } xfer_state_e;

  typedef struct packed {
    logic                     clock_polarity_select;
    logic                     clock_phase_select;
    logic                     select_active_high;
    logic [`SMP_HALF_W-1:0]   half_period;
  } spi_cfg_s;

  typedef struct packed {
    logic                     write;
    logic [`SMP_LEN_W-1:0]    len;
  } xfer_req_s;

  typedef struct packed {
    xfer_state_e              state;
    logic [`SMP_HALF_W-1:0]   half_cnt;
    logic [`SMP_HALF_W-1:0]   half_len;
    logic [`SMP_EDGE_W-1:0]   edge_cnt;
    logic [`SMP_LEN_W-1:0]    bytes_left;
    logic                     write;
    logic                     cpol;
    logic                     cpha;
    logic [`SMP_BYTE_W-1:0]   tx_sh;
    logic [`SMP_BYTE_W-1:0]   rx_sh;
    logic                     sclk;
    logic                     mosi;
    logic                     ss;
    logic                     miso_s1;
    logic                     miso_s2;
    logic                     miso_ie;
    logic                     busy;
    logic                     done;
    logic                     req_ready;
  } engine_s;

endpackage : spi_master_port_pkg
